// ---- core/isp_serial_port.sv ----
`default_nettype none
module isp_serial_port #(
  parameter int FLASH_AW       = spi_prog_pkg::FLASH_ADDR_W,
  parameter int FLASH_PW       = spi_prog_pkg::FLASH_PAGE_W,
  parameter int EE_AW          = spi_prog_pkg::EE_ADDR_W,
  parameter int EE_PW          = spi_prog_pkg::EE_PAGE_W,
  parameter int FLASH_WAIT_CYC = spi_prog_pkg::FLASH_PAGE_WRITE_WAIT_CYC,
  parameter int EE_WAIT_CYC    = spi_prog_pkg::EEPROM_WRITE_WAIT_CYC,
  parameter int ERASE_WAIT_CYC = spi_prog_pkg::FULL_ERASE_WAIT_CYC
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic resetPin_n,
  output logic      miso,
  output logic      progEnabled
);
  import spi_prog_pkg::*;

  logic [2:0]          syncOut;
  logic                sckS, mosiS, inProg, sckPrev_q, sckRise, sckFall, byteDone;
  logic [1:0]          byteIdx;
  logic [7:0]          rxByte;
  logic [7:0]          rxShift_q, rxShift_d, outShift_q, outShift_d;
  logic [7:0]          b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
  logic [4:0]          bitCnt_q, bitCnt_d;
  logic                miso_q, miso_d, enabled_q, enabled_d, cmdValid;
  op_t                 opState_q, opState_d;
  logic [WAIT_W-1:0]   waitCnt_q, waitCnt_d;
  logic [FLASH_AW-1:0] sweep_q, sweep_d, sweepEnd_q, sweepEnd_d, tgt_q, tgt_d;
  logic                sweepDone_q, sweepDone_d;
  logic [7:0]          data_q, data_d;
  logic                flashWe, eeWe, fbufWe, ebufWe;
  logic [FLASH_AW-1:0] flashWa, cmdFa;
  logic [7:0]          flashWlo, flashWhi, eeWd;
  logic [EE_AW-1:0]    eeWa, cmdEa;

  logic [7:0]          flashLo [2**FLASH_AW];
  logic [7:0]          flashHi [2**FLASH_AW];
  logic [7:0]          bufLo   [2**FLASH_PW];
  logic [7:0]          bufHi   [2**FLASH_PW];
  logic [7:0]          eeMem   [2**EE_AW];
  logic [7:0]          eeBuf   [2**EE_PW];

  // pins cross into clk before anything reads them
  sync_2ff #(.WIDTH(3)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({sck, mosi, resetPin_n}),
    .dout   (syncOut)
  );

  assign sckS     = syncOut[2];
  assign mosiS    = syncOut[1];
  assign inProg   = ~syncOut[0];
  assign sckRise  = inProg & sckS & ~sckPrev_q;
  assign sckFall  = inProg & ~sckS & sckPrev_q;
  assign rxByte   = {rxShift_q[6:0], mosiS};
  assign byteIdx  = bitCnt_q[4:3];
  assign byteDone = sckRise & (bitCnt_q[2:0] == 3'h7);
  assign cmdFa    = FLASH_AW'({b2_q, b3_q});
  assign cmdEa    = EE_AW'({b2_q, b3_q});

  // busy pages read as erased so the programmer can poll for completion
  function automatic logic [7:0] readVal(input logic [7:0] c1, input logic [7:0] c2,
                                         input logic [7:0] c3);
    logic [FLASH_AW-1:0] fa;
    logic [EE_AW-1:0]    ea;
    logic [7:0]          v;
    fa = FLASH_AW'({c2, c3});
    ea = EE_AW'({c2, c3});
    v  = 8'h00;
    if ((c1 & ~FLASH_HI_SEL) == CMD_READ_FLASH) begin
      if (opState_q == OP_ERASE || (opState_q == OP_FLASH &&
          fa[FLASH_AW-1:FLASH_PW] == tgt_q[FLASH_AW-1:FLASH_PW])) begin
        v = ERASED_BYTE;
      end else begin
        v = c1[3] ? flashHi[fa] : flashLo[fa];
      end
    end else if (c1 == CMD_READ_EEPROM) begin
      if (opState_q == OP_ERASE || (opState_q == OP_EEBYTE && EE_AW'(tgt_q) == ea) ||
          (opState_q == OP_EEPAGE && ea[EE_AW-1:EE_PW] == tgt_q[EE_AW-1:EE_PW])) begin
        v = ERASED_BYTE;
      end else begin
        v = eeMem[ea];
      end
    end else if (c1 == CMD_POLL_BUSY) begin
      v = {7'h00, opState_q != OP_IDLE};
    end
    return v;
  endfunction

  // link side: framing, echo and read data
  always_comb begin
    rxShift_d  = rxShift_q;
    bitCnt_d   = bitCnt_q;
    b1_d       = b1_q;
    b2_d       = b2_q;
    b3_d       = b3_q;
    outShift_d = outShift_q;
    miso_d     = miso_q;
    enabled_d  = enabled_q;
    cmdValid   = 1'b0;
    if (!inProg) begin
      // dropping reset high abandons any partial frame, which also resyncs
      bitCnt_d   = '0;
      enabled_d  = 1'b0;
      rxShift_d  = '0;
      outShift_d = '0;
      miso_d     = 1'b0;
    end else begin
      if (sckRise) begin
        rxShift_d = rxByte;
        bitCnt_d  = bitCnt_q + 5'h01;
      end
      if (byteDone) begin
        unique case (byteIdx)
          2'h0: b1_d = rxByte;
          2'h1: b2_d = rxByte;
          2'h2: b3_d = rxByte;
          2'h3: cmdValid = enabled_q;
        endcase
        // each byte echoes during the next one, except the third: the fourth carries read data instead
        outShift_d = (byteIdx == 2'h2) ? readVal(b1_q, b2_q, rxByte) : rxByte;
        if (byteIdx == 2'h1 && b1_q == CMD_PROG_ENABLE && rxByte == ENABLE_ECHO) begin
          enabled_d = 1'b1;
        end
      end else if (sckFall) begin
        miso_d     = outShift_q[7];
        outShift_d = {outShift_q[6:0], 1'b0};
      end
    end
  end

  // page buffers accept loads only while no write is running
  assign fbufWe = cmdValid && opState_q == OP_IDLE &&
                  (b1_q & ~FLASH_HI_SEL) == CMD_LOAD_FLASH;
  assign ebufWe = cmdValid && opState_q == OP_IDLE && b1_q == CMD_LOAD_EE_PAGE;

  // self-timed write engine
  always_comb begin
    opState_d   = opState_q;
    waitCnt_d   = waitCnt_q;
    sweep_d     = sweep_q;
    sweepEnd_d  = sweepEnd_q;
    sweepDone_d = sweepDone_q;
    tgt_d       = tgt_q;
    data_d      = data_q;
    unique case (opState_q)
      OP_IDLE: begin
        sweep_d     = '0;
        sweepDone_d = 1'b0;
        if (cmdValid) begin
          if (b1_q == CMD_PROG_ENABLE && b2_q[7:5] == ERASE_B2_TAG) begin
            opState_d  = OP_ERASE;
            tgt_d      = '0;
            sweepEnd_d = '1;
            waitCnt_d  = WAIT_W'(ERASE_WAIT_CYC);
          end else if (b1_q == CMD_WRITE_FLASH_PAGE) begin
            opState_d  = OP_FLASH;
            tgt_d      = {cmdFa[FLASH_AW-1:FLASH_PW], {FLASH_PW{1'b0}}};
            sweepEnd_d = FLASH_AW'((1 << FLASH_PW) - 1);
            waitCnt_d  = WAIT_W'(FLASH_WAIT_CYC);
          end else if (b1_q == CMD_WRITE_EE_BYTE) begin
            opState_d  = OP_EEBYTE;
            tgt_d      = FLASH_AW'(cmdEa);
            data_d     = rxByte;
            sweepEnd_d = '0;
            waitCnt_d  = WAIT_W'(EE_WAIT_CYC);
          end else if (b1_q == CMD_WRITE_EE_PAGE) begin
            opState_d  = OP_EEPAGE;
            tgt_d      = FLASH_AW'({cmdEa[EE_AW-1:EE_PW], {EE_PW{1'b0}}});
            sweepEnd_d = FLASH_AW'((1 << EE_PW) - 1);
            waitCnt_d  = WAIT_W'(EE_WAIT_CYC);
          end
        end
      end
      OP_ERASE, OP_FLASH, OP_EEBYTE, OP_EEPAGE: begin
        if (waitCnt_q != '0) begin
          waitCnt_d = waitCnt_q - WAIT_W'(1);
        end
        if (!sweepDone_q) begin
          sweepDone_d = (sweep_q == sweepEnd_q);
          sweep_d     = sweep_q + FLASH_AW'(1);
        end
        // both the copy and the timed wait must finish before ready
        if (waitCnt_q == '0 && sweepDone_q) begin
          opState_d = OP_IDLE;
        end
      end
    endcase
  end

  // array write ports: one location per cycle while sweeping
  always_comb begin
    flashWe  = 1'b0;
    eeWe     = 1'b0;
    flashWa  = sweep_q;
    flashWlo = ERASED_BYTE;
    flashWhi = ERASED_BYTE;
    eeWa     = EE_AW'(sweep_q);
    eeWd     = ERASED_BYTE;
    if (!sweepDone_q) begin
      unique case (opState_q)
        OP_IDLE: begin
        end
        OP_ERASE: begin
          flashWe = 1'b1;
          eeWe    = 1'b1;
        end
        OP_FLASH: begin
          flashWe  = 1'b1;
          flashWa  = tgt_q | FLASH_AW'(sweep_q[FLASH_PW-1:0]);
          flashWlo = bufLo[sweep_q[FLASH_PW-1:0]];
          flashWhi = bufHi[sweep_q[FLASH_PW-1:0]];
        end
        OP_EEBYTE: begin
          // overwrite replaces the old byte, which stands in for erase-then-write
          eeWe = 1'b1;
          eeWa = EE_AW'(tgt_q);
          eeWd = data_q;
        end
        OP_EEPAGE: begin
          eeWe = 1'b1;
          eeWa = EE_AW'(tgt_q) | EE_AW'(sweep_q[EE_PW-1:0]);
          eeWd = eeBuf[sweep_q[EE_PW-1:0]];
        end
      endcase
    end
  end

  // memories hold no reset; arrays get defined content from erase or writes, buffers only from loads
  always_ff @(posedge clk) begin
    if (flashWe) begin
      flashLo[flashWa] <= flashWlo;
      flashHi[flashWa] <= flashWhi;
    end
    if (eeWe) begin
      eeMem[eeWa] <= eeWd;
    end
    if (fbufWe && b1_q[3]) begin
      bufHi[b3_q[FLASH_PW-1:0]] <= rxByte;
    end
    if (fbufWe && !b1_q[3]) begin
      bufLo[b3_q[FLASH_PW-1:0]] <= rxByte;
    end
    if (ebufWe) begin
      eeBuf[b3_q[EE_PW-1:0]] <= rxByte;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_q   <= 1'b0;
      rxShift_q   <= '0;
      bitCnt_q    <= '0;
      b1_q        <= '0;
      b2_q        <= '0;
      b3_q        <= '0;
      outShift_q  <= '0;
      miso_q      <= 1'b0;
      enabled_q   <= 1'b0;
      opState_q   <= OP_IDLE;
      waitCnt_q   <= '0;
      sweep_q     <= '0;
      sweepEnd_q  <= '0;
      sweepDone_q <= 1'b0;
      tgt_q       <= '0;
      data_q      <= '0;
    end else begin
      sckPrev_q   <= sckS;
      rxShift_q   <= rxShift_d;
      bitCnt_q    <= bitCnt_d;
      b1_q        <= b1_d;
      b2_q        <= b2_d;
      b3_q        <= b3_d;
      outShift_q  <= outShift_d;
      miso_q      <= miso_d;
      enabled_q   <= enabled_d;
      opState_q   <= opState_d;
      waitCnt_q   <= waitCnt_d;
      sweep_q     <= sweep_d;
      sweepEnd_q  <= sweepEnd_d;
      sweepDone_q <= sweepDone_d;
      tgt_q       <= tgt_d;
      data_q      <= data_d;
    end
  end

  assign miso        = miso_q;
  assign progEnabled = enabled_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_enable_head;
    byteDone && byteIdx == 2'h1 && b1_q == CMD_PROG_ENABLE && rxByte == ENABLE_ECHO;
  endsequence
  sequence s_flash_start;
    opState_q == OP_IDLE ##1 opState_q == OP_FLASH;
  endsequence
  sequence s_erase_start;
    opState_q == OP_IDLE ##1 opState_q == OP_ERASE;
  endsequence

  a_echo_enable: assert property (s_enable_head |=> outShift_q == ENABLE_ECHO && enabled_q)
    else $error("enable echo not loaded");
  a_gate_enable: assert property (byteDone && byteIdx == 2'h3 && !enabled_q &&
                                  opState_q == OP_IDLE |=> opState_q == OP_IDLE)
    else $error("operation started before enable");
  a_sample_rise: assert property (sckRise |=> rxShift_q[0] == $past(mosiS))
    else $error("data not sampled on rising edge");
  a_shift_fall: assert property (sckFall |=> miso == $past(outShift_q[7]))
    else $error("data not shifted on falling edge");
  a_leave_prog: assert property (!inProg |=> !progEnabled && bitCnt_q == '0)
    else $error("programming mode kept with reset high");
  a_erase_fill: assert property (s_erase_start |-> flashWe && eeWe &&
                                 flashWlo == ERASED_BYTE && eeWd == ERASED_BYTE)
    else $error("erase does not write 0xFF");
  a_flash_wait: assert property (s_flash_start |-> waitCnt_q == WAIT_W'(FLASH_WAIT_CYC) &&
                                 tgt_q[FLASH_PW-1:0] == '0)
    else $error("flash write wait wrong");
  a_ee_commit: assert property (opState_q == OP_EEBYTE && !sweepDone_q |=>
                                eeMem[$past(eeWa)] == $past(data_q))
    else $error("eeprom byte not written");
  a_flash_poll: assert property (byteDone && byteIdx == 2'h2 && opState_q == OP_FLASH &&
                                 (b1_q & ~FLASH_HI_SEL) == CMD_READ_FLASH &&
                                 FLASH_AW'({b2_q, rxByte}) >> FLASH_PW ==
                                 tgt_q >> FLASH_PW |=> outShift_q == ERASED_BYTE)
    else $error("busy flash page not read as 0xFF");
endmodule
`default_nettype wire

// ---- core/spi_prog_pkg.sv ----
`default_nettype none
package spi_prog_pkg;
  // instruction codes
  localparam logic [7:0] CMD_PROG_ENABLE      = 8'hAC;
  localparam logic [7:0] ENABLE_ECHO          = 8'h53;
  localparam logic [2:0] ERASE_B2_TAG         = 3'h4;
  localparam logic [7:0] CMD_READ_FLASH       = 8'h20;
  localparam logic [7:0] CMD_LOAD_FLASH       = 8'h40;
  localparam logic [7:0] FLASH_HI_SEL         = 8'h08;
  localparam logic [7:0] CMD_WRITE_FLASH_PAGE = 8'h4C;
  localparam logic [7:0] CMD_READ_EEPROM      = 8'hA0;
  localparam logic [7:0] CMD_WRITE_EE_BYTE    = 8'hC0;
  localparam logic [7:0] CMD_LOAD_EE_PAGE     = 8'hC1;
  localparam logic [7:0] CMD_WRITE_EE_PAGE    = 8'hC2;
  localparam logic [7:0] CMD_POLL_BUSY        = 8'hF0;
  localparam logic [7:0] ERASED_BYTE          = 8'hFF;

  // memory geometry
  localparam int FLASH_ADDR_W = 14;
  localparam int FLASH_PAGE_W = 6;
  localparam int EE_ADDR_W    = 10;
  localparam int EE_PAGE_W    = 2;
  localparam int WAIT_W       = 24;

  // timing
  localparam real CLK_FREQ_MHZ           = 250.0;
  localparam real FLASH_PAGE_WRITE_WAIT_MS = 4.5;
  localparam real EEPROM_WRITE_WAIT_MS     = 9.0;
  localparam real FULL_ERASE_WAIT_MS       = 9.0;
  localparam int FLASH_PAGE_WRITE_WAIT_CYC =
    int'($ceil(FLASH_PAGE_WRITE_WAIT_MS * 1000.0 * CLK_FREQ_MHZ));
  localparam int EEPROM_WRITE_WAIT_CYC =
    int'($ceil(EEPROM_WRITE_WAIT_MS * 1000.0 * CLK_FREQ_MHZ));
  localparam int FULL_ERASE_WAIT_CYC =
    int'($ceil(FULL_ERASE_WAIT_MS * 1000.0 * CLK_FREQ_MHZ));

  typedef enum logic [4:0] {
    OP_IDLE   = 5'h01,
    OP_ERASE  = 5'h02,
    OP_FLASH  = 5'h04,
    OP_EEBYTE = 5'h08,
    OP_EEPAGE = 5'h10
  } op_t;
endpackage
`default_nettype wire

// ---- core/sync_2ff.sv ----
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stab_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      stab_q <= '0;
    end else begin
      meta_q <= din;
      stab_q <= meta_q;
    end
  end

  assign dout = stab_q;
endmodule
`default_nettype wire

// ---- testbench/isp_programmer.sv ----
`default_nettype none
module isp_programmer #(
  parameter int HALF_NS       = 80,
  parameter int START_WAIT_NS = 2000
) (
  output logic      sck,
  output logic      mosi,
  output logic      resetPin_n,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    resetPin_n = 1'b0;
    sck        = 1'b0;
    mosi       = 1'b0;
  end

  // a high pulse on reset restarts the frame count
  task automatic pulseReset();
    resetPin_n = 1'b1;
    #(4 * HALF_NS);
    resetPin_n = 1'b0;
    #(START_WAIT_NS);
  endtask

  task automatic endSession();
    resetPin_n = 1'b1;
  endtask

  // whole frames only; sck stands low between frames
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #(HALF_NS);
      rx[i] = miso;
      sck = 1'b1;
      #(HALF_NS);
      sck = 1'b0;
    end
    // mosi keeps its last bit; the next frame sets it in its own time step
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_prog_pkg::*;

  logic        clk;
  logic        arst_n;
  logic        sck;
  logic        mosi;
  logic        resetPin_n;
  logic        miso;
  logic        progEnabled;
  logic [31:0] rx;
  int          fails;
  int          checks;
  int          flashMem [int];
  int          eeMem    [int];

  isp_serial_port #(
    .FLASH_WAIT_CYC(3000),
    .EE_WAIT_CYC   (3000),
    .ERASE_WAIT_CYC(17000)
  ) isp_serial_port_i (
    .clk        (clk),
    .arst_n     (arst_n),
    .sck        (sck),
    .mosi       (mosi),
    .resetPin_n (resetPin_n),
    .miso       (miso),
    .progEnabled(progEnabled)
  );

  isp_programmer #(
    .HALF_NS      (80),
    .START_WAIT_NS(2000)
  ) isp_programmer_i (
    .sck       (sck),
    .mosi      (mosi),
    .resetPin_n(resetPin_n),
    .miso      (miso)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic int expFlash(input int k);
    return flashMem.exists(k) ? flashMem[k] : int'(ERASED_BYTE);
  endfunction

  function automatic int expEe(input int k);
    return eeMem.exists(k) ? eeMem[k] : int'(ERASED_BYTE);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [31:0] tx);
    isp_programmer_i.xfer(tx, rx);
    check(rx[23:16], tx[31:24]);
  endtask

  // busy-flag polling, since data polling misses 0xFF values
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      frame({CMD_POLL_BUSY, 24'h0});
      n++;
    end while (rx[0] !== 1'b0 && n < 40);
    check({7'h0, rx[0]}, 8'h00);
  endtask

  task automatic rdFlash(input int wa, input int hi);
    frame({CMD_READ_FLASH | (hi[0] ? FLASH_HI_SEL : 8'h00), 2'b0, wa[13:0], 8'h00});
  endtask

  task automatic rdEe(input int a);
    frame({CMD_READ_EEPROM, 6'h0, a[9:8], a[7:0], 8'h00});
  endtask

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #390000;
    fails++;
    summarize();
  end

  initial begin
    int         pg;
    int         w;
    int         ea;
    logic [7:0] d;
    fails  = 0;
    checks = 0;
    arst_n = 1'b0;
    void'($urandom(32'h683e));
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    isp_programmer_i.pulseReset();
    isp_programmer_i.xfer({CMD_PROG_ENABLE, 8'h80, 16'h0}, rx);
    check({7'h0, progEnabled}, 8'h00);
    frame({CMD_PROG_ENABLE, ENABLE_ECHO, 16'h0});
    check(rx[15:8], ENABLE_ECHO);
    check({7'h0, progEnabled}, 8'h01);
    $display("test enable done");

    frame({CMD_PROG_ENABLE, 8'h9F, 16'h0});
    flashMem.delete();
    eeMem.delete();
    waitReady();
    for (int k = 0; k < 2; k++) begin
      w = $urandom_range(16383);
      rdFlash(w, k);
      check(rx[7:0], 8'(expFlash(w * 2 + k)));
      ea = $urandom_range(1023);
      rdEe(ea);
      check(rx[7:0], 8'(expEe(ea)));
    end
    $display("test erase done");

    // first and last word of the page, low byte before high byte
    pg = $urandom_range(255);
    for (int k = 0; k < 4; k++) begin
      w = k[1] ? 63 : 0;
      d = 8'($urandom);
      frame({CMD_LOAD_FLASH | (k[0] ? FLASH_HI_SEL : 8'h00), 10'h0, 6'(w), d});
      flashMem[pg * 128 + w * 2 + k[0]] = d;
    end
    frame({CMD_WRITE_FLASH_PAGE, 2'b0, pg[7:2], pg[1:0], 14'h0});
    rdFlash(pg * 64 + 63, 1);
    check(rx[7:0], ERASED_BYTE);
    waitReady();
    for (int k = 0; k < 4; k++) begin
      w = pg * 64 + (k[1] ? 63 : 0);
      rdFlash(w, k[0]);
      check(rx[7:0], 8'(expFlash(w * 2 + k[0])));
    end
    $display("test flash page done");

    // second pass overwrites without an erase in between
    ea = $urandom_range(1023);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      frame({CMD_WRITE_EE_BYTE, 6'h0, ea[9:8], ea[7:0], d});
      eeMem[ea] = d;
      rdEe(ea);
      check(rx[7:0], ERASED_BYTE);
      waitReady();
      rdEe(ea);
      check(rx[7:0], 8'(expEe(ea)));
    end
    $display("test eeprom byte done");

    ea = $urandom_range(1023) & 32'h3FC;
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      frame({CMD_LOAD_EE_PAGE, 8'h00, 8'(k), d});
      eeMem[ea + k] = d;
    end
    frame({CMD_WRITE_EE_PAGE, 6'h0, ea[9:8], ea[7:2], 2'b00, 8'h00});
    waitReady();
    for (int k = 0; k < 4; k++) begin
      rdEe(ea + k);
      check(rx[7:0], 8'(expEe(ea + k)));
    end
    $display("test eeprom page done");

    isp_programmer_i.endSession();
    repeat (20) @(posedge clk);
    #1;
    check({7'h0, progEnabled}, 8'h00);
    $display("test session end done");
    summarize();
  end
endmodule
`default_nettype wire
